// *** hw/cfic_pkg.sv ***
`default_nettype none
package cfic_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ICS_OFFSET = 8'h10;
  localparam int unsigned RX_FLAG_BIT = 31;
  localparam int unsigned RX_LVL_LSB = 16;
  localparam int unsigned TX_FLAG_BIT = 15;
  localparam int unsigned TX_LVL_LSB = 0;
  localparam int unsigned LVL_W = 4;
  localparam int unsigned FILL_W = 5;
  localparam logic [3:0] RX_LVL_RST = 4'h1;
  localparam logic [3:0] TX_LVL_RST = 4'h0;
  localparam logic [3:0] LVL_OFF = 4'h0;
endpackage
`default_nettype wire

// *** hw/cfic_lvl_trig.sv ***
`timescale 1ns/100ps
`default_nettype none
module cfic_lvl_trig (
  input wire logic [cfic_pkg::LVL_W-1:0] level_i,
  input wire logic [cfic_pkg::FILL_W-1:0] count_i,
  input wire logic below_i,
  output logic hit_o
);
  import cfic_pkg::*;

  logic [FILL_W-1:0] lvl_ext;
  always_comb begin
    lvl_ext = {1'b0, level_i};
    if (level_i == LVL_OFF) begin
      hit_o = 1'b0;
    end else if (below_i) begin
      hit_o = (count_i < lvl_ext);
    end else begin
      hit_o = (count_i >= lvl_ext);
    end
  end
endmodule
`default_nettype wire

// *** hw/cfic_top.sv ***
// Summary of operation
// - Register reads zero unless interrupts implemented.
// - Register is 32-bit word at 0x10.
// - Bit 31 receive flag, write-one clears.
// - Receive level bits 19:16, reset 1.
// - Receive flag sets at fill >= level; code requires nonzero receive level.
// - Receive flag sets when FIFO full; code requires nonzero receive level.
// - Receive flag sets on unexpected flag byte; code requires nonzero receive level.
// - Bit 15 transmit flag, absent when unimplemented.
// - Writing one clears transmit flag; zero keeps.
// - Transmit flag reads one after event.
// - Transmit flag resets to zero.
// - Transmit flag sets when remaining below level.
// - Transmit level bits 3:0, reset zero.
`timescale 1ns/100ps
`default_nettype none
module cfic_top (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic rx_irq_implemented_i,
  input wire logic tx_irq_implemented_i,
  input wire logic [cfic_pkg::ADDR_W-1:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o,
  input wire logic [cfic_pkg::FILL_W-1:0] rx_fill_i,
  input wire logic rx_full_i,
  input wire logic rx_odd_flag_i,
  input wire logic [cfic_pkg::FILL_W-1:0] tx_remain_i,
  output logic irq_o
);
  import cfic_pkg::*;

  logic rst_s1;
  logic rst_n;
  logic rx_flag;
  logic tx_flag;
  logic [LVL_W-1:0] rx_level;
  logic [LVL_W-1:0] tx_level;
  logic [31:0] rdata;
  logic irq;
  logic next_rx_flag;
  logic next_tx_flag;
  logic [LVL_W-1:0] next_rx_level;
  logic [LVL_W-1:0] next_tx_level;
  logic [31:0] next_rdata;
  logic next_irq;
  logic rx_thr_hit;
  logic tx_thr_hit;
  logic rx_event;
  logic tx_event;
  logic sel;
  logic any_impl;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  cfic_lvl_trig u_rx_trig (
    .level_i(rx_level),
    .count_i(rx_fill_i),
    .below_i(1'b0),
    .hit_o(rx_thr_hit)
  );

  cfic_lvl_trig u_tx_trig (
    .level_i(tx_level),
    .count_i(tx_remain_i),
    .below_i(1'b1),
    .hit_o(tx_thr_hit)
  );

  always_comb begin
    any_impl = rx_irq_implemented_i | tx_irq_implemented_i;
    sel = (addr_i == ICS_OFFSET);
    // Receive events count only with a nonzero level.
    rx_event = rx_irq_implemented_i & (rx_level != LVL_OFF)
      & (rx_thr_hit | rx_full_i | rx_odd_flag_i);
    tx_event = tx_irq_implemented_i & tx_thr_hit;
    next_rx_flag = rx_flag;
    next_tx_flag = tx_flag;
    next_rx_level = rx_level;
    next_tx_level = tx_level;
    if (sel && wr_i) begin
      if (wdata_i[RX_FLAG_BIT]) begin
        next_rx_flag = 1'b0;
      end
      if (wdata_i[TX_FLAG_BIT]) begin
        next_tx_flag = 1'b0;
      end
      if (rx_irq_implemented_i) begin
        next_rx_level = wdata_i[RX_LVL_LSB +: LVL_W];
      end
      if (tx_irq_implemented_i) begin
        next_tx_level = wdata_i[TX_LVL_LSB +: LVL_W];
      end
    end
    // A new event wins over a clear in the same cycle.
    if (rx_event) begin
      next_rx_flag = 1'b1;
    end
    if (tx_event) begin
      next_tx_flag = 1'b1;
    end
    if (!rx_irq_implemented_i) begin
      next_rx_flag = 1'b0;
    end
    if (!tx_irq_implemented_i) begin
      next_tx_flag = 1'b0;
    end
    next_rdata = 32'h0;
    if (sel && rd_i && any_impl) begin
      next_rdata[RX_FLAG_BIT] = rx_flag & rx_irq_implemented_i;
      next_rdata[TX_FLAG_BIT] = tx_flag & tx_irq_implemented_i;
      if (rx_irq_implemented_i) begin
        next_rdata[RX_LVL_LSB +: LVL_W] = rx_level;
      end
      if (tx_irq_implemented_i) begin
        next_rdata[TX_LVL_LSB +: LVL_W] = tx_level;
      end
    end
    next_irq = next_rx_flag | next_tx_flag;
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_flag <= 1'b0;
      tx_flag <= 1'b0;
      rx_level <= RX_LVL_RST;
      tx_level <= TX_LVL_RST;
      rdata <= 32'h0;
      irq <= 1'b0;
    end else begin
      rx_flag <= next_rx_flag;
      tx_flag <= next_tx_flag;
      rx_level <= next_rx_level;
      tx_level <= next_tx_level;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  assign rdata_o = rdata;
  assign irq_o = irq;

  sequence clr_write_s;
    sel && wr_i && wdata_i[TX_FLAG_BIT] && !tx_event;
  endsequence

  property irq_tracks_p;
    @(posedge mclk_i) disable iff (!rst_n) 1'b1 |=> (irq_o == (rx_flag | tx_flag));
  endproperty

  irq_follow_a: assert property (irq_tracks_p)
    else $error("irq output does not follow flags");
  rx_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    rx_event |=> rx_flag)
    else $error("rx flag not set by event");
  tx_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    tx_event |=> tx_flag)
    else $error("tx flag not set by event");
  tx_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    clr_write_s |=> !tx_flag)
    else $error("tx flag not cleared");
  rx_zero_lvl_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (rx_level == LVL_OFF) && !rx_flag && !(sel && wr_i) |=> !rx_flag)
    else $error("rx flag set while disabled");
  tx_absent_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    !tx_irq_implemented_i |=> !tx_flag)
    else $error("tx flag set while absent");
  res_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    1'b1 |=> (rdata_o[30:20] == 11'h0) && (rdata_o[14:4] == 11'h0))
    else $error("reserved bits nonzero");
  none_impl_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    !any_impl |=> (rdata_o == 32'h0))
    else $error("register visible while absent");
  rx_full_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    rx_full_i && rx_irq_implemented_i && (rx_level != LVL_OFF) |=> rx_flag)
    else $error("full did not raise rx flag");

  sequence rx_clr_write_s;
    sel && wr_i && wdata_i[RX_FLAG_BIT] && !rx_event;
  endsequence

  sequence tx_keep_write_s;
    sel && wr_i && !wdata_i[TX_FLAG_BIT] && tx_flag && tx_irq_implemented_i;
  endsequence

  sequence rx_lvl_write_s;
    sel && wr_i && rx_irq_implemented_i;
  endsequence

  sequence tx_lvl_write_s;
    sel && wr_i && tx_irq_implemented_i;
  endsequence

  sequence rd_req_s;
    sel && rd_i && any_impl;
  endsequence

  sequence odd_hit_s;
    rx_odd_flag_i && rx_irq_implemented_i && (rx_level != LVL_OFF);
  endsequence

  rx_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    rx_clr_write_s |=> !rx_flag)
    else $error("rx flag not cleared");
  tx_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    tx_keep_write_s |=> tx_flag)
    else $error("tx flag lost on zero write");
  rx_odd_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    odd_hit_s |=> rx_flag)
    else $error("flag byte did not raise rx flag");
  rx_lvl_wr_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    rx_lvl_write_s |=> (rx_level == $past(wdata_i[RX_LVL_LSB +: LVL_W])))
    else $error("rx level not written");
  tx_lvl_wr_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    tx_lvl_write_s |=> (tx_level == $past(wdata_i[TX_LVL_LSB +: LVL_W])))
    else $error("tx level not written");
  tx_lvl_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    !tx_irq_implemented_i |=> $stable(tx_level))
    else $error("tx level changed while absent");
  rd_flags_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    rd_req_s |=> (rdata_o[RX_FLAG_BIT] == $past(rx_flag && rx_irq_implemented_i))
      && (rdata_o[TX_FLAG_BIT] == $past(tx_flag && tx_irq_implemented_i)))
    else $error("read data flags wrong");
  rd_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    !(sel && rd_i) |=> (rdata_o == 32'h0))
    else $error("read data not zero when idle");
endmodule
`default_nettype wire

// *** tb/comport_fifo_irq_ctrl_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module comport_fifo_irq_ctrl_tb_top;
  import cfic_pkg::*;
  logic mclk_i = 0, nrst_i = 0, rx_imp = 1, tx_imp = 1, wr = 0, rd = 0, full = 0, odd = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, e;
  logic [4:0] fill = 5'h00, rem = 5'h1f;
  logic [3:0] rl, tl;
  logic irq;
  int seed = 7, error_cnt = 0, checks_done = 0, cyc = 0;

  cfic_top u_cfic_top (.mclk_i(mclk_i), .nrst_i(nrst_i), .rx_irq_implemented_i(rx_imp),
    .tx_irq_implemented_i(tx_imp), .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wdata),
    .rdata_o(rdata), .rx_fill_i(fill), .rx_full_i(full), .rx_odd_flag_i(odd),
    .tx_remain_i(rem), .irq_o(irq));

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  task chk(input logic [31:0] got, input logic [31:0] x);
    checks_done++;
    if (got !== x) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, x);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr = a;
    wdata = d;
    wr = 1;
    @(posedge mclk_i);
    #1 wr = 0;
    @(posedge mclk_i);
    #1;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] x);
    addr = a;
    rd = 1;
    @(posedge mclk_i);
    #1 rd = 0;
    chk(rdata, x);
    @(posedge mclk_i);
    #1;
    chk(rdata, 32'h0);
  endtask

  // Expected register image after one cycle of trigger inputs.
  function logic [31:0] expv(input logic [3:0] r, t, input logic [4:0] f, m,
                             input logic fu, od);
    expv = {(r != 4'h0) && ({1'b0, r} <= f || fu || od), 11'h0, r,
            (t != 4'h0) && (m < {1'b0, t}), 11'h0, t};
  endfunction

  task stop_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      stop_test;
    end
  end

  initial begin
    repeat (3) @(posedge mclk_i);
    #1 nrst_i = 1;
    repeat (3) @(posedge mclk_i);
    #1;
    rd_chk(8'h10, {12'h0, RX_LVL_RST, 12'h0, TX_LVL_RST});
    chk({31'h0, irq}, 32'h0);
    wr_reg(8'h10, 32'hffff_ffff);
    wr_reg(8'h14, 32'h0);
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h10, 32'h000f_000f);
    // A trigger in the cycle of a clearing write must leave the flag set.
    wr_reg(8'h10, 32'h0001_0000);
    addr = 8'h10;
    wdata = 32'h8001_8000;
    wr = 1;
    odd = 1;
    @(posedge mclk_i);
    #1 wr = 0;
    odd = 0;
    @(posedge mclk_i);
    #1;
    rd_chk(8'h10, 32'h8001_0000);
    chk({31'h0, irq}, 32'h1);
    for (int i = 0; i < 40; i++) begin
      rl = 4'($random(seed));
      tl = 4'($random(seed));
      wr_reg(8'h10, {1'b1, 11'h0, rl, 1'b1, 11'h0, tl});
      fill = (i % 4 == 0) ? {1'b0, rl} : 5'({$random(seed)} % 17);
      full = 1'(($random(seed) & 3) == 0);
      odd = 1'(($random(seed) & 3) == 0);
      rem = 5'($random(seed));
      e = expv(rl, tl, fill, rem, full, odd);
      @(posedge mclk_i);
      #1 fill = 5'h00;
      full = 0;
      odd = 0;
      rem = 5'h1f;
      rd_chk(8'h10, e);
      chk({31'h0, irq}, {31'h0, e[31] | e[15]});
      wr_reg(8'h10, e & 32'h7fff_7fff);
      rd_chk(8'h10, e);
    end
    rx_imp = 0;
    full = 1;
    @(posedge mclk_i);
    #1 full = 0;
    rd_chk(8'h10, {16'h0, e[15:0]});
    tx_imp = 0;
    rd_chk(8'h10, 32'h0);
    rx_imp = 1;
    wr_reg(8'h10, {1'b1, 11'h0, 4'h3, 1'b1, 11'h0, ~e[3:0]});
    rd_chk(8'h10, 32'h0003_0000);
    tx_imp = 1;
    rd_chk(8'h10, {12'h0, 4'h3, 12'h0, e[3:0]});
    odd = 1;
    @(posedge mclk_i);
    #1 odd = 0;
    chk({31'h0, irq}, 32'h1);
    nrst_i = 0;
    @(posedge mclk_i);
    #1 nrst_i = 1;
    chk({31'h0, irq}, 32'h0);
    repeat (3) @(posedge mclk_i);
    #1;
    rd_chk(8'h10, {12'h0, RX_LVL_RST, 12'h0, TX_LVL_RST});
    stop_test;
  end
endmodule
`default_nettype wire
